//--- flash_host_regs.vh
// timing counts, pin command encodings and operation codes for the flash command host
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH

// clock rate
`define CLK_MHZ          25
`define CLK_HZ           25000000

// pin timing figures in ns (minimums, rounded up to whole cycles)
`define T_AS_NS          10
`define T_WP_NS          90
`define T_WPH_NS         90
`define T_ACC_NS         70
`define TOGGLE_HIGH_PULSE_MIN_NS 150
`define NS_TO_CYC(t)     ((((t) * `CLK_MHZ) + 999) / 1000)
`define AS_CYC           `NS_TO_CYC(`T_AS_NS)
`define WP_CYC           `NS_TO_CYC(`T_WP_NS)
`define WPH_CYC          `NS_TO_CYC(`T_WPH_NS)
`define ACC_CYC          `NS_TO_CYC(`T_ACC_NS)
`define TOGGLE_HIGH_PULSE_MIN_CYC `NS_TO_CYC(`TOGGLE_HIGH_PULSE_MIN_NS)

// longest erase cycle in seconds, as a polling timeout
`define T_EC_MAX_S       10
`define ERASE_TMO_CYC    (`T_EC_MAX_S * `CLK_HZ)

// command addresses (lower fifteen address lines) and command bytes
`define ADDR_CMD_A       15'h5555
`define ADDR_CMD_B       15'h2aaa
`define CMD_UNLOCK_A     8'haa
`define CMD_UNLOCK_B     8'h55
`define CMD_ERASE_SETUP  8'h80
`define CMD_CHIP_ERASE   8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_ID_ENTRY     8'h90
`define CMD_ID_EXIT      8'hf0
`define CMD_BOOT_LOCK    8'h40
`define CMD_PROGRAM      8'ha0

// boot block word range in the standard variant
`define BOOT_LO          17'h00000
`define BOOT_HI          17'h01fff

// toggle status bit position on the data lines
`define TOGGLE_BIT       6

// host operation codes
`define OP_READ          3'h0
`define OP_CHIP_ERASE    3'h1
`define OP_SECTOR_ERASE  3'h2
`define OP_ID_ENTRY      3'h3
`define OP_ID_EXIT       3'h4
`define OP_BOOT_LOCK     3'h5
`define OP_PROGRAM       3'h6
`define OP_ID_READ       3'h7

`endif

//--- flash_erase_id_toggle_control.v
// host-side sequencer driving a parallel flash through command writes, reads and toggle polling
`timescale 1ns/1ps
`include "flash_host_regs.vh"
`default_nettype none

module flash_erase_id_toggle_control #(
  parameter ADDR_W   = 17,
  parameter DATA_W   = 16,
  parameter POLL_TMO = `ERASE_TMO_CYC
) (
  // clock and reset
  input  wire              ref_clk,
  input  wire              reset,
  // user command port
  input  wire              cmd_valid,
  input  wire [2:0]        cmd_op,
  input  wire [ADDR_W-1:0] cmd_addr,
  input  wire [DATA_W-1:0] cmd_wdata,
  output wire              cmd_ready,
  output reg               done_ff,
  output reg               timeout_ff,
  output reg               boot_hit_ff,
  output reg  [DATA_W-1:0] rd_data_ff,
  // flash pins
  output reg  [ADDR_W-1:0] flash_addr_ff,
  output reg  [DATA_W-1:0] flash_dq_out_ff,
  output reg               flash_dq_oe_ff,
  input  wire [DATA_W-1:0] flash_dq_in,
  output reg               flash_ce_n_ff,
  output reg               flash_oe_n_ff,
  output reg               flash_we_n_ff,
  output reg               flash_rst_n_ff
);

  // one-hot states
  localparam [5:0] ST_IDLE  = 6'b000001;
  localparam [5:0] ST_WSET  = 6'b000010;
  localparam [5:0] ST_WLOW  = 6'b000100;
  localparam [5:0] ST_WHIGH = 6'b001000;
  localparam [5:0] ST_READ  = 6'b010000;
  localparam [5:0] ST_GAP   = 6'b100000;

  // last count of each timed phase, worked out wide and cut to the counters on purpose
  localparam integer AS_N     = `AS_CYC;
  localparam integer WP_N     = `WP_CYC - 1;
  localparam integer WPH_N    = `WPH_CYC - 1;
  localparam integer RD_N     = `ACC_CYC;
  localparam integer TOG_N    = `TOGGLE_HIGH_PULSE_MIN_CYC - 1;
  localparam integer TMO_N    = POLL_TMO - 1;
  localparam [3:0]   AS_LAST  = AS_N[3:0];
  localparam [3:0]   WP_LAST  = WP_N[3:0];
  localparam [3:0]   WPH_LAST = WPH_N[3:0];
  localparam [3:0]   RD_LAST  = RD_N[3:0];
  localparam [3:0]   TOG_LAST = TOG_N[3:0];
  localparam [27:0]  TMO_LAST = TMO_N[27:0];

  reg [5:0]        state_ff;
  reg [3:0]        cnt_ff;
  reg [2:0]        op_ff;
  reg [2:0]        step_ff;
  reg [ADDR_W-1:0] uaddr_ff;
  reg [DATA_W-1:0] udata_ff;
  reg              poll_ff;
  reg              have_prev_ff;
  reg              prev_tog_ff;
  reg [27:0]       poll_cnt_ff;

  wire [ADDR_W+DATA_W-1:0] cur_word;
  wire [2:0]               last_step;
  wire                     op_polls;

  // address and data of one write in a command sequence
  function [ADDR_W+DATA_W-1:0] seq_word;
    input [2:0]        op;
    input [2:0]        step;
    input [ADDR_W-1:0] ua;
    input [DATA_W-1:0] ud;
    reg   [14:0]       ca;
    reg   [7:0]        cd;
    begin
      ca = `ADDR_CMD_A;
      cd = `CMD_UNLOCK_A;
      case (step)
        3'd1, 3'd4: begin
          ca = `ADDR_CMD_B;
          cd = `CMD_UNLOCK_B;
        end
        3'd2: begin
          if (op == `OP_ID_ENTRY)
            cd = `CMD_ID_ENTRY;
          else if (op == `OP_ID_EXIT)
            cd = `CMD_ID_EXIT;
          else if (op == `OP_PROGRAM)
            cd = `CMD_PROGRAM;
          else
            cd = `CMD_ERASE_SETUP;
        end
        3'd5: begin
          if (op == `OP_CHIP_ERASE)
            cd = `CMD_CHIP_ERASE;
          else if (op == `OP_SECTOR_ERASE)
            cd = `CMD_SECTOR_ERASE;
          else
            cd = `CMD_BOOT_LOCK;
        end
        default: begin
          ca = `ADDR_CMD_A;
          cd = `CMD_UNLOCK_A;
        end
      endcase
      // upper data byte and upper address lines held low in commands, except the user address in the sector erase write and user address and data in the program write
      seq_word = {{(ADDR_W-15){1'b0}}, ca, {(DATA_W-8){1'b0}}, cd};
      if (op == `OP_PROGRAM && step == 3'd3)
        seq_word = {ua, ud};
      else if (op == `OP_SECTOR_ERASE && step == 3'd5)
        seq_word = {ua, {(DATA_W-8){1'b0}}, `CMD_SECTOR_ERASE};
    end
  endfunction

  // sequence length and whether completion must be polled
  assign last_step = (op_ff == `OP_PROGRAM) ? 3'd3 :
                     (op_ff == `OP_ID_ENTRY || op_ff == `OP_ID_EXIT) ? 3'd2 : 3'd5;
  assign op_polls  = (op_ff == `OP_CHIP_ERASE) || (op_ff == `OP_SECTOR_ERASE) ||
                     (op_ff == `OP_BOOT_LOCK) || (op_ff == `OP_PROGRAM);
  assign cur_word  = seq_word(op_ff, step_ff, uaddr_ff, udata_ff);

  // commands taken only when idle, so polling holds off the next sequence
  assign cmd_ready = (state_ff == ST_IDLE);

  // sequencer; one process keeps pin timing and state in step
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff        <= ST_IDLE;
      cnt_ff          <= 4'h0;
      op_ff           <= 3'h0;
      step_ff         <= 3'h0;
      uaddr_ff        <= {ADDR_W{1'b0}};
      udata_ff        <= {DATA_W{1'b0}};
      poll_ff         <= 1'b0;
      have_prev_ff    <= 1'b0;
      prev_tog_ff     <= 1'b0;
      poll_cnt_ff     <= 28'h0;
      done_ff         <= 1'b0;
      timeout_ff      <= 1'b0;
      boot_hit_ff     <= 1'b0;
      rd_data_ff      <= {DATA_W{1'b0}};
      flash_addr_ff   <= {ADDR_W{1'b0}};
      flash_dq_out_ff <= {DATA_W{1'b0}};
      flash_dq_oe_ff  <= 1'b0;
      flash_ce_n_ff   <= 1'b1;
      flash_oe_n_ff   <= 1'b1;
      flash_we_n_ff   <= 1'b1;
      flash_rst_n_ff  <= 1'b0;
    end else begin
      flash_rst_n_ff <= 1'b1;
      done_ff        <= 1'b0;
      cnt_ff         <= cnt_ff + 4'h1;
      if (poll_ff)
        poll_cnt_ff <= poll_cnt_ff + 28'h1;
      case (state_ff)
        ST_IDLE: begin
          cnt_ff         <= 4'h0;
          flash_ce_n_ff  <= 1'b1;
          flash_oe_n_ff  <= 1'b1;
          flash_we_n_ff  <= 1'b1;
          flash_dq_oe_ff <= 1'b0;
          if (cmd_valid) begin
            op_ff        <= cmd_op;
            step_ff      <= 3'h0;
            uaddr_ff     <= cmd_addr;
            udata_ff     <= cmd_wdata;
            poll_ff      <= 1'b0;
            have_prev_ff <= 1'b0;
            poll_cnt_ff  <= 28'h0;
            timeout_ff   <= 1'b0;
            // a program aimed at the boot block may be refused if locked
            boot_hit_ff  <= (cmd_op == `OP_PROGRAM) && (cmd_addr <= `BOOT_HI);
            if (cmd_op == `OP_READ) begin
              flash_addr_ff <= cmd_addr;
              state_ff      <= ST_READ;
            end else if (cmd_op == `OP_ID_READ) begin
              flash_addr_ff <= {{(ADDR_W-1){1'b0}}, cmd_addr[0]};
              state_ff      <= ST_READ;
            end else
              state_ff <= ST_WSET;
          end
        end
        // address and data stand a setup time before the strobe falls, else the latch races
        ST_WSET: begin
          flash_addr_ff   <= cur_word[ADDR_W+DATA_W-1:DATA_W];
          flash_dq_out_ff <= cur_word[DATA_W-1:0];
          flash_dq_oe_ff  <= 1'b1;
          flash_ce_n_ff   <= 1'b0;
          flash_oe_n_ff   <= 1'b1;
          if (cnt_ff == AS_LAST) begin
            cnt_ff        <= 4'h0;
            flash_we_n_ff <= 1'b0;
            state_ff      <= ST_WLOW;
          end
        end
        ST_WLOW: begin
          if (cnt_ff == WP_LAST) begin
            cnt_ff        <= 4'h0;
            flash_we_n_ff <= 1'b1;
            state_ff      <= ST_WHIGH;
          end
        end
        // data held through the high half; next write, polling or the done pulse follows
        ST_WHIGH: begin
          if (cnt_ff == WPH_LAST) begin
            cnt_ff         <= 4'h0;
            flash_dq_oe_ff <= 1'b0;
            if (step_ff != last_step) begin
              step_ff  <= step_ff + 3'h1;
              state_ff <= ST_WSET;
            end else if (op_polls) begin
              // poll at the last written address, kept for every read
              poll_ff       <= 1'b1;
              flash_ce_n_ff <= 1'b1;
              state_ff      <= ST_GAP;
            end else begin
              flash_ce_n_ff <= 1'b1;
              done_ff       <= 1'b1;
              state_ff      <= ST_IDLE;
            end
          end
        end
        // read with chip select and output enable low, sample at access time
        ST_READ: begin
          flash_ce_n_ff <= 1'b0;
          flash_oe_n_ff <= 1'b0;
          if (cnt_ff == RD_LAST) begin
            cnt_ff        <= 4'h0;
            flash_ce_n_ff <= 1'b1;
            flash_oe_n_ff <= 1'b1;
            rd_data_ff    <= flash_dq_in;
            if (!poll_ff) begin
              done_ff  <= 1'b1;
              state_ff <= ST_IDLE;
            end else if (have_prev_ff && (flash_dq_in[`TOGGLE_BIT] == prev_tog_ff)) begin
              // level itself means nothing; only a stopped toggle counts
              poll_ff  <= 1'b0;
              done_ff  <= 1'b1;
              state_ff <= ST_IDLE;
            end else if (poll_cnt_ff >= TMO_LAST) begin
              poll_ff    <= 1'b0;
              timeout_ff <= 1'b1;
              done_ff    <= 1'b1;
              state_ff   <= ST_IDLE;
            end else begin
              have_prev_ff <= 1'b1;
              prev_tog_ff  <= flash_dq_in[`TOGGLE_BIT];
              state_ff     <= ST_GAP;
            end
          end
        end
        // both strobes high for the toggle high-pulse minimum
        ST_GAP: begin
          flash_ce_n_ff <= 1'b1;
          flash_oe_n_ff <= 1'b1;
          if (cnt_ff == TOG_LAST) begin
            cnt_ff   <= 4'h0;
            state_ff <= ST_READ;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- flash_ctl_props.sv
// concurrent checks on the pins of the flash command host
`timescale 1ns/1ps
`default_nettype none
module flash_ctl_props #(
  parameter ADDR_W = 17,
  parameter DATA_W = 16
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              reset,
  // user command port
  input wire logic              cmd_valid,
  input wire logic [2:0]        cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic              cmd_ready,
  // flash pins
  input wire logic [ADDR_W-1:0] flash_addr_ff,
  input wire logic [DATA_W-1:0] flash_dq_out_ff,
  input wire logic              flash_ce_n_ff,
  input wire logic              flash_oe_n_ff,
  input wire logic              flash_we_n_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [2:0]        op_ff, nw_ff;
  logic [ADDR_W-1:0] ca_ff, wa_ff;
  wire acc  = cmd_valid && cmd_ready;
  wire wr   = !flash_we_n_ff;
  wire poll = !cmd_ready && op_ff != 3'h0 && op_ff != 3'h3 && op_ff != 3'h4 && op_ff != 3'h7;
  // latch the command, count its write pulses, keep the last written address
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      op_ff <= 3'h0;
      nw_ff <= 3'h0;
      ca_ff <= '0;
      wa_ff <= '0;
    end else begin
      if (acc)
        op_ff <= cmd_op;
      if (acc)
        ca_ff <= cmd_addr;
      if (wr)
        wa_ff <= flash_addr_ff;
      nw_ff <= acc ? 3'h0 : nw_ff + {2'b00, $fell(flash_we_n_ff)};
    end
  end
  // a write strobe: three cycles low with select on and reads off, then three high
  sequence we_pulse_s;
    (wr && !flash_ce_n_ff && flash_oe_n_ff) [*3] ##1 !wr [*3];
  endsequence
  we_oe_a: assert property (wr |-> flash_oe_n_ff && !flash_ce_n_ff)
    else $error("output enable low in write");
  we_pulse_a: assert property ($fell(flash_we_n_ff) |-> we_pulse_s)
    else $error("bad write pulse");
  upper_zero_a: assert property (wr && op_ff != 3'h6 |-> flash_dq_out_ff[15:8] == 8'h00)
    else $error("upper command byte not zero");
  chip_final_a: assert property (wr && op_ff == 3'h1 && nw_ff == 3'h6 |->
    flash_addr_ff[14:0] == 15'h5555 && flash_dq_out_ff[7:0] == 8'h10) else $error("bad chip erase write");
  sector_final_a: assert property (wr && op_ff == 3'h2 && nw_ff == 3'h6 |->
    flash_addr_ff == ca_ff && flash_dq_out_ff[7:0] == 8'h30) else $error("bad sector erase write");
  toggle_high_a: assert property ($rose(flash_oe_n_ff) && poll |-> flash_oe_n_ff [*4])
    else $error("short toggle high pulse");
  poll_addr_a: assert property (poll && !flash_oe_n_ff |-> flash_addr_ff == wa_ff)
    else $error("polling address moved");
  id_read_a: assert property (acc && cmd_op == 3'h7 |-> ##[1:4]
    (!flash_oe_n_ff && flash_addr_ff == {{(ADDR_W-1){1'b0}}, ca_ff[0]})) else $error("bad id read");
  busy_pins_a: assert property (wr || !flash_oe_n_ff |-> !cmd_ready)
    else $error("ready while pins active");
endmodule
bind flash_erase_id_toggle_control flash_ctl_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_flash_ctl_props (
  .ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
  .cmd_ready(cmd_ready), .flash_addr_ff(flash_addr_ff), .flash_dq_out_ff(flash_dq_out_ff),
  .flash_ce_n_ff(flash_ce_n_ff), .flash_oe_n_ff(flash_oe_n_ff), .flash_we_n_ff(flash_we_n_ff));
`default_nettype wire

//--- flash_dev_model.sv
// behavioural flash: command decode, id mode, toggle polling
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter        TOGGLES = 5,
  parameter [15:0] MAKER   = 16'h00a5, // arbitrary value
  parameter [15:0] PART    = 16'h005a  // arbitrary value
) (
  // bus pins
  input  wire logic [16:0] addr,
  input  wire logic [15:0] dq_in,
  output wire logic [15:0] dq_out,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n
);
  logic [14:0] ha [0:5];
  logic [7:0]  hd [0:5];
  logic        id_mode = 1'b0;
  logic        lock = 1'b0, pend = 1'b0, tog = 1'b0, bsy = 1'b0, chip_er = 1'b0, u3, u6;
  logic [3:0]  sec_er = 4'h0;
  logic        stall  = 1'b0; // bench sets it for an erase of 1000 toggles, longer than the polling timeout
  logic [16:0] poll_a;
  logic [15:0] rdv;
  int          busy_n = 0, pgm_n = 0, addr_err = 0;
  wire         wr = !ce_n && !we_n;
  wire         rd = !ce_n && !oe_n;
  // decode at the end of each write pulse; history keeps the unlock steps
  always @(negedge wr) begin
    for (int i = 5; i > 0; i--) begin
      ha[i] = ha[i-1];
      hd[i] = hd[i-1];
    end
    ha[0] = addr[14:0];
    hd[0] = dq_in[7:0];
    poll_a = addr;
    u3 = ha[2] == 15'h5555 && hd[2] == 8'haa && ha[1] == 15'h2aaa && hd[1] == 8'h55;
    u6 = u3 && hd[5] == 8'haa && hd[4] == 8'h55 && hd[3] == 8'h80;
    if (pend && !(lock && addr <= 17'h01fff)) begin
      pgm_n++;
      busy_n = TOGGLES;
    end
    if (hd[0] == 8'hf0) id_mode = 1'b0;
    if (u3 && hd[0] == 8'h90) id_mode = 1'b1;
    if (u6 && hd[0] == 8'h40) lock = 1'b1;
    if (u6 && hd[0] == 8'h10 && ha[0] == 15'h5555) chip_er = 1'b1;
    if (u6 && hd[0] == 8'h30) sec_er = addr[16:13];
    if (u6 && (hd[0] == 8'h10 || hd[0] == 8'h30)) busy_n = stall ? 1000 : TOGGLES;
    pend = u3 && hd[0] == 8'ha0;
  end
  // every read start while busy flips the status bit
  always @(posedge rd) begin
    bsy = busy_n != 0;
    if (bsy) begin
      tog = ~tog;
      busy_n--;
      addr_err += addr != poll_a;
    end
  end
  // deselected bus shows the inverse so stale data never looks valid
  always @* begin
    if (bsy)
      rdv = {9'h000, tog, 6'h00};
    else if (id_mode && addr[16:1] == 16'h0000)
      rdv = addr[0] ? PART : MAKER;
    else
      rdv = addr[15:0] ^ 16'hc3c3;
  end
  assign dq_out = rd ? rdv : ~rdv;
endmodule
`default_nettype wire

//--- flash_erase_id_toggle_control_tb.sv
// self-checking bench: flash command host against the flash model
`timescale 1ns/1ps
`include "flash_host_regs.vh"
`default_nettype none
module flash_erase_id_toggle_control_tb;
  logic        ref_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0;
  logic [2:0]  cmd_op = 3'h0;
  logic [16:0] cmd_addr = 17'h00000;
  logic [15:0] cmd_wdata = 16'h0000;
  wire         cmd_ready, done_ff, timeout_ff, boot_hit_ff, dq_oe, ce_n, oe_n, we_n, rst_n;
  wire  [15:0] rd_data_ff, dq_out, dev_q;
  wire  [16:0] addr;
  int          failures = 0, checked = 0;
  // shared data wire, host wins while it drives
  wire  [15:0] bus = dq_oe ? dq_out : dev_q;
  always #20 ref_clk = ~ref_clk;
  flash_erase_id_toggle_control #(.POLL_TMO(2000)) i_flash_erase_id_toggle_control (
    .ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done_ff(done_ff), .timeout_ff(timeout_ff),
    .boot_hit_ff(boot_hit_ff), .rd_data_ff(rd_data_ff), .flash_addr_ff(addr), .flash_dq_out_ff(dq_out),
    .flash_dq_oe_ff(dq_oe), .flash_dq_in(bus), .flash_ce_n_ff(ce_n), .flash_oe_n_ff(oe_n),
    .flash_we_n_ff(we_n), .flash_rst_n_ff(rst_n));
  flash_dev_model i_flash_dev_model (.addr(addr), .dq_in(bus), .dq_out(dev_q), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one command, then a bounded wait for its done pulse
  task automatic run(input logic [2:0] op, input logic [16:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    while (done_ff !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    if (done_ff !== 1'b1) begin
      chk(32'(done_ff), 32'h1);
      conclude();
    end
  endtask
  task automatic t_id;
    run(`OP_ID_ENTRY, 17'h0, 16'h0);
    run(`OP_ID_READ, 17'h0, 16'h0);
    chk(32'(rd_data_ff), 32'(i_flash_dev_model.MAKER));
    run(`OP_ID_READ, 17'h1, 16'h0);
    chk(32'(rd_data_ff), 32'(i_flash_dev_model.PART));
    run(`OP_ID_EXIT, 17'h0, 16'h0);
    run(`OP_READ, 17'h1, 16'h0);
    chk(32'(rd_data_ff), 32'h0000c3c2);
    $display("id test done");
  endtask
  task automatic t_erase;
    run(`OP_CHIP_ERASE, 17'h0, 16'h0);
    chk(32'(i_flash_dev_model.chip_er), 32'h1);
    chk(32'(i_flash_dev_model.busy_n), 32'h0);
    chk(32'(timeout_ff), 32'h0);
    run(`OP_SECTOR_ERASE, 17'h04000, 16'h0);
    chk(32'(i_flash_dev_model.sec_er), 32'h2);
    chk(32'(i_flash_dev_model.busy_n), 32'h0);
    chk(32'(i_flash_dev_model.addr_err), 32'h0);
    $display("erase test done");
  endtask
  task automatic t_lock;
    run(`OP_BOOT_LOCK, 17'h0, 16'h0);
    chk(32'(i_flash_dev_model.lock), 32'h1);
    run(`OP_PROGRAM, `BOOT_HI, 16'h1234);
    chk(32'(boot_hit_ff), 32'h1);
    chk(32'(i_flash_dev_model.pgm_n), 32'h0);
    run(`OP_PROGRAM, `BOOT_HI + 17'h1, 16'habcd);
    chk(32'(boot_hit_ff), 32'h0);
    chk(32'(i_flash_dev_model.pgm_n), 32'h1);
    $display("lock test done");
  endtask
  // an erase longer than the polling timeout: polling must give up and flag it, the next command clears the flag
  task automatic t_timeout;
    i_flash_dev_model.stall = 1'b1;
    run(`OP_CHIP_ERASE, 17'h0, 16'h0);
    chk(32'(timeout_ff), 32'h1);
    i_flash_dev_model.stall = 1'b0;
    i_flash_dev_model.busy_n = 0;
    run(`OP_READ, 17'h00010, 16'h0);
    chk(32'(timeout_ff), 32'h0);
    $display("timeout test done");
  endtask
  // mid-run reset: pins go quiet, device reset pin stays low until the first edge after release
  task automatic t_reset;
    @(posedge ref_clk);
    reset <= 1'b1;
    @(negedge ref_clk);
    chk(32'(rst_n), 32'h0);
    chk(32'({ce_n, oe_n, we_n, dq_oe}), 32'he);
    chk(32'(cmd_ready), 32'h1);
    @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk(32'(rst_n), 32'h0);
    @(negedge ref_clk);
    chk(32'(rst_n), 32'h1);
    run(`OP_READ, 17'h00010, 16'h0);
    chk(32'(rd_data_ff), 32'h0000c3d3);
    $display("reset test done");
  endtask
  task automatic conclude;
    $display("checks=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    t_id();
    t_erase();
    t_lock();
    t_timeout();
    t_reset();
    conclude();
  end
endmodule
`default_nettype wire
